// *** hdl/ppp_top.sv ***
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module ppp_top (
   input wire logic MCLK,
   input wire logic ARST_N,
   // Avalon-MM slave, byte addresses.
   input wire logic [8:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Pads.
   input wire logic [8:0][15:0] PIN_IN,
   output ppp_pkg::ppp_drive_t [8:0] PIN_DRIVE,
   output logic [8:0][1:0] THRESH_SEL,
   // Alternate functions.
   input wire ppp_pkg::ppp_alt_t [8:0] ALT_CTRL,
   output logic [8:0][15:0] ALT_IN,
   // External bus controller.
   input wire logic XBUS_MUX_EN,
   input wire logic XBUS_AD_OE,
   input wire logic [15:0] XBUS_AD_OUT,
   input wire logic XBUS_DEMUX_EN,
   input wire logic [15:0] XBUS_ADDR_OUT,
   input wire logic XBUS_SEG_EN,
   input wire logic [7:0] XBUS_SEG,
   output logic [15:0] XBUS_AD_IN
);

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic logic [15:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   function automatic logic [15:0] merge(
      input logic [15:0] old_v,
      input logic [15:0] new_v,
      input logic [15:0] m
   );
      merge = (old_v & ~m) | (new_v & m);
   endfunction : merge

   // Source of a read-modify-write is what a read of the data register shows.
   function automatic logic [15:0] rmw(
      input logic [2:0] sel,
      input logic [15:0] src,
      input logic [15:0] w
   );
      logic [15:0] r;
      r = w;
      case (sel)
         ppp_pkg::SEL_SET: begin
            r = src | w;
         end
         ppp_pkg::SEL_CLR: begin
            r = src & ~w;
         end
         ppp_pkg::SEL_TGL: begin
            r = src ^ w;
         end
         default: begin
            r = w;
         end
      endcase
      rmw = r;
   endfunction : rmw

   // Write strobe for one register of the addressed port.
   function automatic logic strobe(
      input logic hit,
      input logic [2:0] sel,
      input logic [2:0] want
   );
      strobe = hit & (sel == want);
   endfunction : strobe

   // Register view of one port for a read; write-only selects read zero.
   function automatic logic [15:0] port_view(
      input logic [2:0] sel,
      input logic [15:0] data_v,
      input logic [15:0] dir_v,
      input logic [15:0] odm_v,
      input logic [15:0] pin_v,
      input logic [15:0] lat_v
   );
      case (sel)
         ppp_pkg::SEL_DATA: port_view = data_v;
         ppp_pkg::SEL_DIR: port_view = dir_v;
         ppp_pkg::SEL_ODM: port_view = odm_v;
         ppp_pkg::SEL_PIN: port_view = pin_v;
         ppp_pkg::SEL_LATCH: port_view = lat_v;
         default: port_view = 16'h0000;
      endcase
   endfunction : port_view

   // Threshold select bits of one port: two for wide ports, one for byte ports.
   function automatic logic [1:0] thr_bits(
      input int port,
      input logic [9:0] t,
      input logic [3:0] x
   );
      case (port)
         0: thr_bits = t[ppp_pkg::THR_P0 +: 2];
         1: thr_bits = t[ppp_pkg::THR_P1 +: 2];
         2: thr_bits = t[ppp_pkg::THR_P2 +: 2];
         3: thr_bits = t[ppp_pkg::THR_P3 +: 2];
         5: thr_bits = t[ppp_pkg::THR_P5 +: 2];
         4: thr_bits = {1'b0, x[ppp_pkg::XTHR_P4]};
         6: thr_bits = {1'b0, x[ppp_pkg::XTHR_P6]};
         7: thr_bits = {1'b0, x[ppp_pkg::XTHR_P7]};
         8: thr_bits = {1'b0, x[ppp_pkg::XTHR_P8]};
         default: thr_bits = 2'b00;
      endcase
   endfunction : thr_bits

   // -------------------------------------------------------------------------
   // Bus handshake
   // -------------------------------------------------------------------------
   ppp_pkg::ppp_bus_state_t state;
   ppp_pkg::ppp_bus_state_t next_state;

   wire logic req = AVS_READ | AVS_WRITE;
   wire logic in_ack = (state == ppp_pkg::BUS_ACK);
   wire logic commit = in_ack & AVS_WRITE;

   always_comb begin
      next_state = state;
      case (state)
         ppp_pkg::BUS_IDLE: begin
            if (req) begin
               next_state = ppp_pkg::BUS_ACK;
            end
         end
         ppp_pkg::BUS_ACK: begin
            next_state = ppp_pkg::BUS_IDLE;
         end
         default: begin
            next_state = ppp_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ppp_pkg::BUS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // One wait cycle: read data is registered in the first cycle and stands
   // at the edge where waitrequest is low.
   assign AVS_WAITREQUEST = req & ~in_ack;

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   wire logic [3:0] acc_port = AVS_ADDRESS[8:5];
   wire logic [2:0] acc_sel = AVS_ADDRESS[4:2];
   wire logic aligned = (AVS_ADDRESS[1:0] == 2'b00);
   wire logic hit_port = aligned & (acc_port < ppp_pkg::PORT_COUNT);
   wire logic hit_thr = aligned & (AVS_ADDRESS == ppp_pkg::OFS_THR);
   wire logic hit_xthr = aligned & (AVS_ADDRESS == ppp_pkg::OFS_XTHR);
   wire logic [15:0] wmask = lane_mask(AVS_BYTEENABLE);
   wire logic [15:0] wdata = AVS_WRITEDATA[15:0];

   // -------------------------------------------------------------------------
   // Port registers and pin slices
   // -------------------------------------------------------------------------
   // Nets: every port slice and register group drives its own element.
   wire logic [8:0][15:0] latch;
   wire logic [8:0][15:0] dir;
   wire logic [8:0][15:0] odm;
   wire logic [8:0][15:0] in_latch;
   wire logic [8:0][15:0] read_val;
   wire ppp_pkg::ppp_drive_t [8:0] drive_all;
   ppp_pkg::ppp_auto_t [8:0] auto_ctl;

   genvar p;
   generate
      for (p = 0; p < ppp_pkg::NPORT; p = p + 1) begin : g_port
         localparam logic [15:0] LINES = ppp_pkg::PORT_MASK[p];
         localparam logic [15:0] OUT_LINES = LINES & {16{ppp_pkg::OUT_CAP[p]}};
         localparam logic [15:0] OD_LINES = LINES & {16{ppp_pkg::OD_CAP[p]}};

         // Register state of this port.
         logic [15:0] port_latch;
         logic [15:0] port_dir;
         logic [15:0] port_odm;

         assign latch[p] = port_latch;
         assign dir[p] = port_dir;
         assign odm[p] = port_odm;

         wire logic sel_me = hit_port & (acc_port == 4'(p));
         wire logic wr_data = strobe(commit & sel_me, acc_sel, ppp_pkg::SEL_DATA);
         wire logic wr_rmw = commit & sel_me & (acc_sel >= ppp_pkg::SEL_SET) &
                             (acc_sel <= ppp_pkg::SEL_TGL);
         wire logic wr_dir = strobe(commit & sel_me, acc_sel, ppp_pkg::SEL_DIR);
         wire logic wr_odm = strobe(commit & sel_me, acc_sel, ppp_pkg::SEL_ODM);
         wire logic [15:0] rmw_val = rmw(acc_sel, read_val[p], wdata);
         wire logic [15:0] next_latch = wr_data ? merge(latch[p], wdata, wmask & OUT_LINES) :
                                        merge(latch[p], rmw_val, wmask & OUT_LINES);
         wire logic [15:0] next_dir = merge(dir[p], wdata, wmask & OUT_LINES);
         wire logic [15:0] next_odm = merge(odm[p], wdata, wmask & OD_LINES);

         always_ff @(posedge MCLK or negedge ARST_N) begin
            if (!ARST_N) begin
               port_latch <= ppp_pkg::RST_LATCH;
               port_dir <= ppp_pkg::RST_DIR;
               port_odm <= ppp_pkg::RST_ODM;
            end else begin
               if (wr_data | wr_rmw) begin
                  port_latch <= next_latch;
               end
               if (wr_dir) begin
                  port_dir <= next_dir;
               end
               if (wr_odm) begin
                  port_odm <= next_odm;
               end
            end
         end

         ppp_port_slice #(
            .MASK(LINES),
            .OUT_OK(ppp_pkg::OUT_CAP[p]),
            .OD_OK(ppp_pkg::OD_CAP[p])
         ) u_slice (
            .mclk(MCLK),
            .arst_n(ARST_N),
            .pin_in(PIN_IN[p]),
            .latch(latch[p]),
            .dir(dir[p]),
            .od(odm[p]),
            .alt(ALT_CTRL[p]),
            .auto_ctl(auto_ctl[p]),
            .drive(drive_all[p]),
            .in_latch(in_latch[p]),
            .read_val(read_val[p])
         );
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Pad and alternate outputs
   // -------------------------------------------------------------------------
   // Alternate inputs see the sampled pin, which carries the driven value
   // (latch, alternate or bus output) while its output enable is on.
   assign ALT_IN = in_latch;
   assign PIN_DRIVE = drive_all;
   assign XBUS_AD_IN = in_latch[0];

   // -------------------------------------------------------------------------
   // Hardware direction control for the external bus
   // -------------------------------------------------------------------------
   // Port 0 carries multiplexed address/data, port 1 demultiplexed address,
   // port 4 low byte the upper segment address lines.
   always_comb begin
      auto_ctl = '0;
      auto_ctl[0].en = {16{XBUS_MUX_EN}};
      auto_ctl[0].oe = {16{XBUS_AD_OE}};
      auto_ctl[0].data = XBUS_AD_OUT;
      auto_ctl[1].en = {16{XBUS_DEMUX_EN}};
      auto_ctl[1].oe = {16{XBUS_DEMUX_EN}};
      auto_ctl[1].data = XBUS_ADDR_OUT;
      auto_ctl[4].en = {8'h00, {8{XBUS_SEG_EN}}};
      auto_ctl[4].oe = {8'h00, {8{XBUS_SEG_EN}}};
      auto_ctl[4].data = {8'h00, XBUS_SEG};
   end

   // -------------------------------------------------------------------------
   // Input threshold selection
   // -------------------------------------------------------------------------
   logic [9:0] thr;
   logic [3:0] xthr;

   wire logic wr_thr = commit & hit_thr;
   wire logic wr_xthr = commit & hit_xthr & AVS_BYTEENABLE[0];
   wire logic [9:0] next_thr = 10'(merge({6'h00, thr}, wdata, wmask));
   wire logic [3:0] next_xthr = wdata[3:0];

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         thr <= ppp_pkg::RST_THR;
         xthr <= ppp_pkg::RST_XTHR;
      end else begin
         if (wr_thr) begin
            thr <= next_thr;
         end
         if (wr_xthr) begin
            xthr <= next_xthr;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Threshold outputs
   // -------------------------------------------------------------------------
   // Two select bits for the wide ports, one for each byte port.
   assign THRESH_SEL = {
      thr_bits(8, thr, xthr),
      thr_bits(7, thr, xthr),
      thr_bits(6, thr, xthr),
      thr_bits(5, thr, xthr),
      thr_bits(4, thr, xthr),
      thr_bits(3, thr, xthr),
      thr_bits(2, thr, xthr),
      thr_bits(1, thr, xthr),
      thr_bits(0, thr, xthr)
   };

   // -------------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------------
   wire logic [3:0] rd_port = hit_port ? acc_port : 4'h0;
   wire logic [15:0] rd_word = port_view(acc_sel, read_val[rd_port], dir[rd_port],
      odm[rd_port], in_latch[rd_port], latch[rd_port]);
   wire logic [15:0] rd_any =
      hit_port ? rd_word :
      hit_thr ? {6'h00, thr} :
      hit_xthr ? {12'h000, xthr} : 16'h0000;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ & ~in_ack) begin
         AVS_READDATA <= {16'h0000, rd_any};
      end
   end

endmodule : ppp_top

`default_nettype wire

// *** inc/ppp_pkg.sv ***
package ppp_pkg;

   // -------------------------------------------------------------------------
   // Geometry
   // -------------------------------------------------------------------------
   localparam int NPORT = 9;
   localparam int PW = 16;
   localparam int AW = 9;
   localparam logic [3:0] PORT_COUNT = 4'h9;
   localparam logic [3:0] THR_PORT = 4'h9;

   // Implemented lines per port, port 8 first.
   localparam logic [NPORT-1:0][PW-1:0] PORT_MASK = {
      16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF,
      16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
   // Ports that own an output path and ports with open drain drivers.
   localparam logic [NPORT-1:0] OUT_CAP = 9'h1DF;
   localparam logic [NPORT-1:0] OD_CAP = 9'h1DC;

   // -------------------------------------------------------------------------
   // Register map: port p at byte p*0x20, thresholds after the last port
   // -------------------------------------------------------------------------
   localparam logic [2:0] SEL_DATA = 3'h0;
   localparam logic [2:0] SEL_DIR = 3'h1;
   localparam logic [2:0] SEL_ODM = 3'h2;
   localparam logic [2:0] SEL_SET = 3'h3;
   localparam logic [2:0] SEL_CLR = 3'h4;
   localparam logic [2:0] SEL_TGL = 3'h5;
   localparam logic [2:0] SEL_PIN = 3'h6;
   localparam logic [2:0] SEL_LATCH = 3'h7;
   localparam logic [2:0] SEL_THR = 3'h0;
   localparam logic [2:0] SEL_XTHR = 3'h1;
   localparam logic [AW-1:0] OFS_THR = 9'h120;
   localparam logic [AW-1:0] OFS_XTHR = 9'h124;

   // -------------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------------
   localparam logic [PW-1:0] RST_LATCH = 16'h0000;
   localparam logic [PW-1:0] RST_DIR = 16'h0000;
   localparam logic [PW-1:0] RST_ODM = 16'h0000;
   localparam logic [9:0] RST_THR = 10'h000;
   localparam logic [3:0] RST_XTHR = 4'h0;

   // -------------------------------------------------------------------------
   // Threshold field positions (bit pairs for ports 0,1,2,3,5)
   // -------------------------------------------------------------------------
   localparam int THR_P0 = 0;
   localparam int THR_P1 = 2;
   localparam int THR_P2 = 4;
   localparam int THR_P3 = 6;
   localparam int THR_P5 = 8;
   localparam int XTHR_P4 = 0;
   localparam int XTHR_P6 = 1;
   localparam int XTHR_P7 = 2;
   localparam int XTHR_P8 = 3;

   // -------------------------------------------------------------------------
   // Timing: one pin sample per state time
   // -------------------------------------------------------------------------
   localparam int MCLK_NS = 40;
   localparam int STATE_TIME_NS = 40;
   localparam int SAMPLE_CYCLES = (STATE_TIME_NS + MCLK_NS - 1) / MCLK_NS;

   // -------------------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [PW-1:0] oe;
      logic [PW-1:0] out;
   } ppp_drive_t;

   typedef struct packed {
      logic [PW-1:0] en;
      logic [PW-1:0] data;
      logic [PW-1:0] pwm;
   } ppp_alt_t;

   typedef struct packed {
      logic [PW-1:0] en;
      logic [PW-1:0] oe;
      logic [PW-1:0] data;
   } ppp_auto_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } ppp_bus_state_t;

endpackage : ppp_pkg

// *** hdl/ppp_port_slice.sv ***
`timescale 1ns/100ps
`default_nettype none

module ppp_port_slice #(
   parameter logic [15:0] MASK = 16'hFFFF,
   parameter logic OUT_OK = 1'b1,
   parameter logic OD_OK = 1'b0
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] latch,
   input wire logic [15:0] dir,
   input wire logic [15:0] od,
   input wire ppp_pkg::ppp_alt_t alt,
   input wire ppp_pkg::ppp_auto_t auto_ctl,
   output ppp_pkg::ppp_drive_t drive,
   output logic [15:0] in_latch,
   output logic [15:0] read_val
);

   // -------------------------------------------------------------------------
   // Output path
   // -------------------------------------------------------------------------
   wire logic [15:0] out_lines = MASK & {16{OUT_OK}};
   wire logic [15:0] alt_value = alt.data & (alt.pwm | latch);
   wire logic [15:0] gp_value = (alt.en & alt_value) | (~alt.en & latch);
   wire logic [15:0] value = (auto_ctl.en & auto_ctl.data) | (~auto_ctl.en & gp_value);
   wire logic [15:0] dir_eff = (auto_ctl.en & auto_ctl.oe) | (~auto_ctl.en & dir);
   wire logic [15:0] od_eff = od & ~auto_ctl.en & {16{OD_OK}};
   // Open drain releases the pin for a one; the threshold plays no part here.
   wire logic [15:0] next_oe = out_lines & dir_eff & (~od_eff | ~value);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         drive <= '0;
         in_latch <= '0;
      end else begin
         drive.oe <= next_oe;
         drive.out <= value & out_lines;
         in_latch <= pin_in & MASK;
      end
   end

   // -------------------------------------------------------------------------
   // Software view of the data register
   // -------------------------------------------------------------------------
   assign read_val = (dir & latch) | (~dir & in_latch);

endmodule : ppp_port_slice

`default_nettype wire

// *** test/ppp_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none

module ppp_monitor (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic [8:0][15:0] PIN_IN,
   input wire ppp_pkg::ppp_drive_t [8:0] PIN_DRIVE,
   input wire logic [8:0][1:0] THRESH_SEL,
   input wire logic [8:0][15:0] ALT_IN,
   input wire logic XBUS_MUX_EN,
   input wire logic XBUS_AD_OE,
   input wire logic [15:0] XBUS_AD_OUT,
   input wire logic XBUS_DEMUX_EN,
   input wire logic [15:0] XBUS_ADDR_OUT,
   input wire logic XBUS_SEG_EN,
   input wire logic [7:0] XBUS_SEG,
   input wire logic [15:0] XBUS_AD_IN
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!ARST_N);

   property p_rst_idle;
      $rose(ARST_N) |-> PIN_DRIVE == '0 && THRESH_SEL == '0;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("pads not idle after reset");
   property p_port5_in;
      PIN_DRIVE[5].oe == 16'h0000;
   endproperty
   a_port5_in: assert property (p_port5_in) else $error("input only port drives");
   property p_absent;
      PIN_DRIVE[3].oe[14] == 1'b0 && PIN_DRIVE[4].oe[15:8] == 8'h00
         && PIN_DRIVE[6].oe[15:8] == 8'h00 && PIN_DRIVE[7].oe[15:8] == 8'h00
         && PIN_DRIVE[8].oe[15:8] == 8'h00;
   endproperty
   a_absent: assert property (p_absent) else $error("absent line drives");
   property p_sample;
      $past(ARST_N) |-> ALT_IN[2] == $past(PIN_IN[2]) && ALT_IN[5] == $past(PIN_IN[5]);
   endproperty
   a_sample: assert property (p_sample) else $error("pin sample missed");
   property p_ad_in;
      XBUS_AD_IN == ALT_IN[0];
   endproperty
   a_ad_in: assert property (p_ad_in) else $error("bus data input differs");
   property p_demux;
      XBUS_DEMUX_EN |=> PIN_DRIVE[1] == {16'hFFFF, $past(XBUS_ADDR_OUT)};
   endproperty
   a_demux: assert property (p_demux) else $error("address lines not driven");
   property p_mux_drv;
      XBUS_MUX_EN && XBUS_AD_OE |=> PIN_DRIVE[0] == {16'hFFFF, $past(XBUS_AD_OUT)};
   endproperty
   a_mux_drv: assert property (p_mux_drv) else $error("bus lines not driven");
   property p_mux_rel;
      XBUS_MUX_EN && !XBUS_AD_OE |=> PIN_DRIVE[0].oe == 16'h0000;
   endproperty
   a_mux_rel: assert property (p_mux_rel) else $error("bus lines not released");
   property p_seg;
      XBUS_SEG_EN |=> PIN_DRIVE[4].oe[7:0] == 8'hFF && PIN_DRIVE[4].out[7:0] == $past(XBUS_SEG);
   endproperty
   a_seg: assert property (p_seg) else $error("segment lines wrong");
   property p_thr_byte;
      THRESH_SEL[4][1] == 1'b0 && THRESH_SEL[7][1] == 1'b0 && THRESH_SEL[8][1] == 1'b0;
   endproperty
   a_thr_byte: assert property (p_thr_byte) else $error("extra threshold bit");
endmodule : ppp_monitor

`default_nettype wire

// *** test/ppp_pin_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module ppp_pin_model (
   input wire logic mclk,
   input wire ppp_pkg::ppp_drive_t [8:0] drive,
   input wire logic [8:0][15:0] ext_en,
   input wire logic [8:0][15:0] ext_val,
   output logic [8:0][15:0] level
);
   logic [8:0][15:0] last_lvl = '0;

   always @(posedge mclk) begin
      last_lvl <= level;
   end
   // A line nobody drives has no pull, so it wanders away from its last level.
   always_comb begin
      for (int p = 0; p < 9; p++) begin
         for (int b = 0; b < 16; b++) begin
            if (drive[p].oe[b]) begin
               level[p][b] = drive[p].out[b];
            end else if (ext_en[p][b]) begin
               level[p][b] = ext_val[p][b];
            end else begin
               level[p][b] = ~last_lvl[p][b];
            end
         end
      end
   end
endmodule : ppp_pin_model

`default_nettype wire

// *** test/ppp_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module ppp_top_tb;
   logic mclk, arst_n, rd_s, wr_s, mux_en, ad_oe, demux_en, seg_en, wreq;
   logic [8:0] addr;
   logic [31:0] wdata, rdata, dummy;
   logic [8:0][15:0] pin, alt_in, ext_en, ext_val;
   ppp_pkg::ppp_drive_t [8:0] drv;
   ppp_pkg::ppp_alt_t [8:0] alt;
   logic [8:0][1:0] thr;
   logic [15:0] ad_out, addr_out, ad_in;
   logic [7:0] seg;
   int err_count, total_checks, cyc;

   ppp_top uut (.MCLK(mclk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_s),
      .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .PIN_IN(pin), .PIN_DRIVE(drv), .THRESH_SEL(thr),
      .ALT_CTRL(alt), .ALT_IN(alt_in), .XBUS_MUX_EN(mux_en), .XBUS_AD_OE(ad_oe),
      .XBUS_AD_OUT(ad_out), .XBUS_DEMUX_EN(demux_en), .XBUS_ADDR_OUT(addr_out),
      .XBUS_SEG_EN(seg_en), .XBUS_SEG(seg), .XBUS_AD_IN(ad_in));
   ppp_pin_model u_pins (.mclk(mclk), .drive(drv), .ext_en(ext_en), .ext_val(ext_val),
      .level(pin));

   task automatic give_verdict();
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // -------------------------------------------------------------------
   // Avalon-MM master: request held until waitrequest is seen low.
   // -------------------------------------------------------------------
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_s <= w;
      rd_s <= !w;
      do begin
         @(posedge mclk);
      end while (wreq);
      q = rdata;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask : bus

   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      bus(1'b1, a, d, dummy);
   endtask : wr

   task automatic rdchk(input logic [8:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(q, exp);
   endtask : rdchk

   // Drive edge, pad sample edge, then one spare edge; wr returns on the commit edge.
   task automatic settle();
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask : settle

   task automatic s_reset();
      for (int p = 0; p < 9; p++) check(drv[p], 32'h0000_0000);
      rdchk(9'h044, 32'h0000_0000);
      rdchk(9'h048, 32'h0000_0000);
      rdchk(9'h05C, 32'h0000_0000);
      rdchk(9'h120, 32'h0000_0000);
   endtask : s_reset

   task automatic s_inout();
      @(posedge mclk);
      ext_en[2] <= 16'hFFFF;
      ext_val[2] <= 16'hA5C3;
      wr(9'h040, 32'h0000_3C3C);
      settle();
      rdchk(9'h040, 32'h0000_A5C3);
      rdchk(9'h05C, 32'h0000_3C3C);
      check({16'h0000, drv[2].oe}, 32'h0000_0000);
      wr(9'h04C, 32'h0000_0004);
      rdchk(9'h05C, 32'h0000_A5C7);
      @(posedge mclk);
      ext_en[2] <= 16'h0000;
      wr(9'h044, 32'h0000_FFFF);
      settle();
      check(drv[2], 32'hFFFF_A5C7);
      rdchk(9'h040, 32'h0000_A5C7);
      check({16'h0000, alt_in[2]}, 32'h0000_A5C7);
      wr(9'h054, 32'h0000_00FF);
      settle();
      check(drv[2], 32'hFFFF_A538);
      rdchk(9'h05C, 32'h0000_A538);
      wr(9'h048, 32'h0000_FFFF);
      settle();
      check(drv[2], 32'h5AC7_A538);
      wr(9'h008, 32'h0000_FFFF);
      rdchk(9'h008, 32'h0000_0000);
      wr(9'h048, 32'h0000_0000);
   endtask : s_inout

   task automatic s_lines();
      wr(9'h064, 32'h0000_FFFF);
      rdchk(9'h064, 32'h0000_BFFF);
      wr(9'h084, 32'h0000_FFFF);
      rdchk(9'h084, 32'h0000_00FF);
      wr(9'h0A4, 32'h0000_FFFF);
      rdchk(9'h0A4, 32'h0000_0000);
      rdchk(9'h0A0, 32'h0000_6E91);
      rdchk(9'h140, 32'h0000_0000);
      settle();
      check({16'h0000, drv[3].oe}, 32'h0000_BFFF);
      wr(9'h120, 32'h0000_03FF);
      wr(9'h124, 32'h0000_000F);
      rdchk(9'h120, 32'h0000_03FF);
      rdchk(9'h124, 32'h0000_000F);
      settle();
      check({24'h00_0000, thr[2], thr[5], thr[8], thr[4]}, 32'h0000_00F5);
      check(drv[2], 32'hFFFF_A538);
   endtask : s_lines

   task automatic alt_case(input logic [15:0] lat, input logic [15:0] dat,
      input logic [15:0] pwm, input logic exp);
      wr(9'h0E0, {16'h0000, lat});
      @(posedge mclk);
      alt[7] <= {16'h0001, dat, pwm};
      settle();
      check({31'h0000_0000, drv[7].out[0]}, {31'h0000_0000, exp});
   endtask : alt_case

   task automatic s_alt();
      wr(9'h0E4, 32'h0000_00FF);
      alt_case(16'h00FF, 16'h0000, 16'h0000, 1'b0);
      alt_case(16'h00FF, 16'h0001, 16'h0000, 1'b1);
      alt_case(16'h00FE, 16'h0001, 16'h0000, 1'b0);
      alt_case(16'h00FE, 16'h0001, 16'h0001, 1'b1);
      wr(9'h0E4, 32'h0000_0000);
      settle();
      check({16'h0000, drv[7].oe}, 32'h0000_0000);
   endtask : s_alt

   task automatic s_xbus();
      @(posedge mclk);
      demux_en <= 1'b1;
      addr_out <= 16'h1234;
      seg_en <= 1'b1;
      seg <= 8'h5A;
      mux_en <= 1'b1;
      ext_en[0] <= 16'hFFFF;
      ext_val[0] <= 16'hBEEF;
      settle();
      check(drv[1], 32'hFFFF_1234);
      check({16'h0000, drv[4].oe[7:0], drv[4].out[7:0]}, 32'h0000_FF5A);
      check({16'h0000, drv[0].oe}, 32'h0000_0000);
      check({16'h0000, ad_in}, 32'h0000_BEEF);
      @(posedge mclk);
      ext_en[0] <= 16'h0000;
      ad_oe <= 1'b1;
      ad_out <= 16'h1357;
      settle();
      check(drv[0], 32'hFFFF_1357);
   endtask : s_xbus

   // Mid-run reset: bus controls dropped first, then all drives, the port 2 direction, open drain and latch registers and the threshold register must clear.
   task automatic s_rerst();
      @(posedge mclk);
      {mux_en, ad_oe, demux_en, seg_en} <= 4'h0;
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      @(negedge mclk);
      s_reset();
   endtask : s_rerst

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_count++;
         give_verdict();
      end
   end

   initial begin
      {arst_n, rd_s, wr_s, mux_en, ad_oe, demux_en, seg_en} = '0;
      {addr, wdata, ad_out, addr_out, seg, alt} = '0;
      {err_count, total_checks, cyc} = '0;
      ext_en = '0;
      ext_val = '0;
      ext_en[5] = 16'hFFFF;
      ext_val[5] = 16'h6E91;
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      @(negedge mclk);
      s_reset();
      s_inout();
      s_lines();
      s_alt();
      s_xbus();
      s_rerst();
      give_verdict();
   end
endmodule : ppp_top_tb

bind ppp_top ppp_monitor u_mon (.MCLK(MCLK), .ARST_N(ARST_N), .PIN_IN(PIN_IN),
   .PIN_DRIVE(PIN_DRIVE), .THRESH_SEL(THRESH_SEL), .ALT_IN(ALT_IN),
   .XBUS_MUX_EN(XBUS_MUX_EN), .XBUS_AD_OE(XBUS_AD_OE), .XBUS_AD_OUT(XBUS_AD_OUT),
   .XBUS_DEMUX_EN(XBUS_DEMUX_EN), .XBUS_ADDR_OUT(XBUS_ADDR_OUT), .XBUS_SEG_EN(XBUS_SEG_EN),
   .XBUS_SEG(XBUS_SEG), .XBUS_AD_IN(XBUS_AD_IN));

`default_nettype wire
